/* File: hw/slow_clock_periodic_timer.sv */
// slow clock periodic timer: wishbone registers, interrupts and timer core
// Operation
// [RQ1] prescaler register is 8-bit read/write, cleared at reset
// [RQ2] bits 2 to 0 of prescaler select the slow clock divide factor
// [RQ3] codes 000 to 101 divide by 1, 2, 4, 8, 16, 32
// [RQ4] software uses only codes 000 to 101; others are undefined
// [RQ5] preset register is 16-bit read/write, all ones after reset
// [RQ6] counter reloads from preset on every underflow
// [RQ7] one period spans preset plus one ticks
// [RQ8] software loads preset only with 0001h to FFFFh
// [RQ9] control and status register is 8-bit read/write, cleared at reset
// [RQ10] setting restart reloads counter from preset on a tick
// [RQ11] restart acts on next tick then clears itself; new preset waits
// [RQ12] at zero: one-tick pulse, terminal count set, interrupt if enabled
// [RQ13] writes leave terminal count alone; a read of the register clears it
// [RQ14] bits: restart 0, count 1, irq enable 2, watchdog 3, freeze 4
// [RQ15] reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module slow_clock_periodic_timer
    import slow_timer_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic slow_clock,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [SEL_W-1:0] wb_sel,
    input wire logic [DATA_W-1:0] wb_dat_w,
    output logic [DATA_W-1:0] wb_dat_r,
    output logic wb_ack,
    output logic timer_tick_clock,
    output logic underflow_pulse,
    output logic timer_irq
);
    timer_link_if #(.WIDTH(TIMER_W)) link ();

    logic ack_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DIV_W-1:0] divider_q;
    logic [TIMER_W-1:0] preset_q;
    logic restart_q;
    logic term_flag_q;
    logic irq_en_q;
    logic wd_status_q;
    logic freeze_q;
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_event;
    logic access;
    logic wr;
    logic rd;
    reg_sel_t sel;
    logic wr_ctrl;
    logic [CTRL_W-1:0] ctrl_view;

    // bus request qualification, one access per ack
    assign access = wb_cyc & wb_stb & ~ack_q;
    assign wr = access & wb_we;
    assign rd = access & ~wb_we;
    assign sel = decode_reg(wb_adr);
    assign wr_ctrl = wr & (sel == SEL_CTRL) & wb_sel[0];

    // control and status view in bit order
    always_comb begin
        ctrl_view = '0;
        ctrl_view[CTRL_RESTART_BIT] = restart_q; // RQ14
        ctrl_view[CTRL_TERM_BIT] = term_flag_q;
        ctrl_view[CTRL_IRQ_EN_BIT] = irq_en_q;
        ctrl_view[CTRL_WD_BIT] = wd_status_q;
        ctrl_view[CTRL_FREEZE_BIT] = freeze_q;
    end

    // read data mux, unused bits zero
    always_comb begin
        rdata_d = '0;
        unique case (sel)
            SEL_PRESCALER: rdata_d[DIV_LSB +: DIV_W] = divider_q; // RQ15
            SEL_PRESET: rdata_d[TIMER_W-1:0] = preset_q;
            SEL_CTRL: rdata_d[CTRL_W-1:0] = ctrl_view; // RQ15
            SEL_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_status_q;
            SEL_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
            SEL_COUNT: rdata_d[TIMER_W-1:0] = link.count;
            SEL_NONE: rdata_d = '0;
        endcase
    end

    // ack one cycle after the strobe, read data latched with it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= access;
            if (rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // prescaler divider field, upper bits not stored
    always_ff @(posedge clock) begin
        if (!resetn) begin
            divider_q <= DIVIDER_RESET; // RQ1
        end else if (wr && (sel == SEL_PRESCALER) && wb_sel[0]) begin
            divider_q <= wb_dat_w[DIV_LSB +: DIV_W]; // RQ2 RQ4
        end
    end

    // preset, one byte lane per byte
    for (genvar b = 0; b < TIMER_W / 8; b++) begin : g_preset_lane
        always_ff @(posedge clock) begin
            if (!resetn) begin
                preset_q[8*b +: 8] <= PRESET_RESET[8*b +: 8]; // RQ5
            end else if (wr && (sel == SEL_PRESET) && wb_sel[b]) begin
                preset_q[8*b +: 8] <= wb_dat_w[8*b +: 8]; // RQ8
            end
        end
    end

    // plain control bits of the control and status register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_en_q <= 1'b0; // RQ9
            wd_status_q <= 1'b0;
            freeze_q <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_q <= wb_dat_w[CTRL_IRQ_EN_BIT]; // RQ14
            wd_status_q <= wb_dat_w[CTRL_WD_BIT];
            freeze_q <= wb_dat_w[CTRL_FREEZE_BIT];
        end
    end

    // restart request: write one sets, done pulse clears, set wins
    always_ff @(posedge clock) begin
        if (!resetn) begin
            restart_q <= 1'b0;
        end else if (wr_ctrl && wb_dat_w[CTRL_RESTART_BIT]) begin
            restart_q <= 1'b1; // RQ10
        end else if (link.restart_done) begin
            restart_q <= 1'b0; // RQ11
        end
    end

    // terminal count: set at zero, cleared by a read, set wins
    always_ff @(posedge clock) begin
        if (!resetn) begin
            term_flag_q <= 1'b0;
        end else if (link.zero_event) begin
            term_flag_q <= 1'b1; // RQ12
        end else if (rd && (sel == SEL_CTRL)) begin
            term_flag_q <= 1'b0; // RQ13
        end
    end

    // interrupt events
    assign irq_event[IRQ_UNDERFLOW_BIT] = link.zero_event & irq_en_q; // RQ12
    assign irq_event[IRQ_RESTART_BIT] = link.restart_done;

    // sticky status bits, write one clears, event wins
    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq_status
        always_ff @(posedge clock) begin
            if (!resetn) begin
                irq_status_q[i] <= IRQ_RESET[i];
            end else if (irq_event[i]) begin
                irq_status_q[i] <= 1'b1;
            end else if (wr && (sel == SEL_IRQ_STATUS) && wb_sel[0] && wb_dat_w[i]) begin
                irq_status_q[i] <= 1'b0;
            end
        end
    end

    // interrupt mask
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_mask_q <= IRQ_RESET;
        end else if (wr && (sel == SEL_IRQ_MASK) && wb_sel[0]) begin
            irq_mask_q <= wb_dat_w[IRQ_W-1:0];
        end
    end

    // timer core hookup
    assign link.restart_req = restart_q;
    assign link.preset = preset_q; // RQ11

    tick_prescaler_gen u_prescaler (
        .clock(clock),
        .resetn(resetn),
        .slow_clock(slow_clock),
        .slow_clock_divider(divider_q),
        .link(link)
    );

    reload_down_counter #(.WIDTH(TIMER_W)) u_counter (
        .clock(clock),
        .resetn(resetn),
        .link(link)
    );

    // outputs
    assign wb_ack = ack_q;
    assign wb_dat_r = rdata_q;
    assign timer_tick_clock = link.tick;
    assign underflow_pulse = link.underflow;
    assign timer_irq = |(irq_status_q & irq_mask_q);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_ack_single;
        wb_ack |=> !wb_ack;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

    property p_preset_after_reset;
        $rose(resetn) |-> preset_q == PRESET_RESET;
    endproperty
    a_preset_after_reset: assert property (p_preset_after_reset) // RQ5
        else $error("bad preset reset");

    property p_ctrl_after_reset;
        $rose(resetn) |-> (ctrl_view == '0) && (divider_q == DIVIDER_RESET);
    endproperty
    a_ctrl_after_reset: assert property (p_ctrl_after_reset) else $error("bad ctrl reset"); // RQ9

    property p_term_set;
        link.zero_event |=> term_flag_q;
    endproperty
    a_term_set: assert property (p_term_set) else $error("terminal count not set"); // RQ12

    property p_term_write_keeps;
        wr_ctrl && !link.zero_event |=> term_flag_q == $past(term_flag_q);
    endproperty
    a_term_write_keeps: assert property (p_term_write_keeps) // RQ13
        else $error("write moved count flag");

    property p_term_read_clears;
        rd && (sel == SEL_CTRL) && !link.zero_event |=> !term_flag_q;
    endproperty
    a_term_read_clears: assert property (p_term_read_clears) // RQ13
        else $error("read left count flag");

    property p_restart_self_clear;
        link.restart_done && !(wr_ctrl && wb_dat_w[CTRL_RESTART_BIT]) |=> !restart_q;
    endproperty
    a_restart_self_clear: assert property (p_restart_self_clear) // RQ11
        else $error("restart stuck");

    property p_irq_on_zero;
        link.zero_event && irq_en_q && irq_mask_q[IRQ_UNDERFLOW_BIT] |=> timer_irq;
    endproperty
    a_irq_on_zero: assert property (p_irq_on_zero) else $error("no interrupt at zero"); // RQ12

    property p_reserved_zero;
        rd && (sel == SEL_PRESCALER || sel == SEL_CTRL) |=> wb_dat_r[DATA_W-1:CTRL_W] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RQ15
        else $error("reserved bits not zero");
endmodule
`default_nettype wire

/* File: hw/slow_timer_pkg.sv */
// constants, types and decode helpers for the slow clock periodic timer
`default_nettype none
package slow_timer_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    // byte offsets of the registers
    localparam logic [7:0] OFS_PRESCALER = 8'h00;
    localparam logic [7:0] OFS_PRESET = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    // values after reset
    localparam logic [2:0] DIVIDER_RESET = 3'h0;
    localparam logic [15:0] PRESET_RESET = 16'hFFFF;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // prescaler field layout
    localparam int DIV_W = 3;
    localparam int DIV_LSB = 0;
    localparam logic [2:0] DIV_MAX_CODE = 3'h5;
    localparam int DIV_CNT_W = 5;
    localparam logic [4:0] DIV_RESERVED_LIMIT = 5'h1F;
    // control and status bit positions
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_TERM_BIT = 1;
    localparam int CTRL_IRQ_EN_BIT = 2;
    localparam int CTRL_WD_BIT = 3;
    localparam int CTRL_FREEZE_BIT = 4;
    localparam int CTRL_W = 5;
    // interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_UNDERFLOW_BIT = 0;
    localparam int IRQ_RESTART_BIT = 1;
    localparam int TIMER_W = 16;

    typedef enum logic [2:0] {
        SEL_PRESCALER, SEL_PRESET, SEL_CTRL, SEL_IRQ_STATUS, SEL_IRQ_MASK, SEL_COUNT, SEL_NONE
    } reg_sel_t;

    // terminal value of the divider counter for a divider code
    function automatic logic [4:0] div_limit(input logic [2:0] code);
        if (code > DIV_MAX_CODE) begin
            return DIV_RESERVED_LIMIT;
        end
        return 5'((6'h01 << code) - 6'h01);
    endfunction

    // byte address to register select
    function automatic reg_sel_t decode_reg(input logic [7:0] adr);
        case (adr)
            OFS_PRESCALER: return SEL_PRESCALER;
            OFS_PRESET: return SEL_PRESET;
            OFS_CTRL: return SEL_CTRL;
            OFS_IRQ_STATUS: return SEL_IRQ_STATUS;
            OFS_IRQ_MASK: return SEL_IRQ_MASK;
            OFS_COUNT: return SEL_COUNT;
            default: return SEL_NONE;
        endcase
    endfunction
endpackage
`default_nettype wire

/* File: hw/timer_link_if.sv */
// link between the tick prescaler, the down-counter and the register block
`timescale 1ns/1ps
`default_nettype none
interface timer_link_if #(parameter int WIDTH = 16) ();
    logic tick;
    logic restart_req;
    logic [WIDTH-1:0] preset;
    logic [WIDTH-1:0] count;
    logic zero_event;
    logic underflow;
    logic restart_done;

    modport prescaler (output tick);
    modport counter (
        input tick, restart_req, preset,
        output count, zero_event, underflow, restart_done
    );
    modport ctrl (
        input tick, count, zero_event, underflow, restart_done,
        output restart_req, preset
    );
endinterface
`default_nettype wire

/* File: hw/tick_prescaler_gen.sv */
// slow clock edge detect and programmable power-of-two tick divider
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler_gen
    import slow_timer_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic slow_clock,
    input wire logic [DIV_W-1:0] slow_clock_divider,
    timer_link_if.prescaler link
);
    logic slow_prev_q;
    logic [DIV_CNT_W-1:0] div_cnt_q;
    logic tick_q;
    logic slow_edge;
    logic [DIV_CNT_W-1:0] limit;

    // rising edge of the slow clock and the divide limit
    assign slow_edge = slow_clock & ~slow_prev_q;
    assign limit = div_limit(slow_clock_divider); // RQ3

    // previous slow clock level
    always_ff @(posedge clock) begin
        if (!resetn) begin
            slow_prev_q <= 1'b1; // no false edge if the slow clock is high at release
        end else begin
            slow_prev_q <= slow_clock;
        end
    end

    // divide slow edges down to one tick per 2^code edges, 32 edges for codes 110 and 111
    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (slow_edge) begin
                if (div_cnt_q >= limit) begin // RQ2
                    div_cnt_q <= '0;
                    tick_q <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 1'b1;
                end
            end
        end
    end

    assign link.tick = tick_q;

    property p_div_by_one;
        @(posedge clock) disable iff (!resetn)
        slow_edge && (slow_clock_divider == DIVIDER_RESET) |=> link.tick;
    endproperty
    a_div_by_one: assert property (p_div_by_one) else $error("code 000 did not tick"); // RQ3

    property p_div_by_two;
        @(posedge clock) disable iff (!resetn)
        slow_edge && (slow_clock_divider == 3'h1) && (div_cnt_q == '0) |=> !link.tick;
    endproperty
    a_div_by_two: assert property (p_div_by_two) else $error("code 001 ticked early"); // RQ3
endmodule
`default_nettype wire

/* File: hw/reload_down_counter.sv */
// down-counter with preset reload on underflow or restart
`timescale 1ns/1ps
`default_nettype none
module reload_down_counter
    import slow_timer_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    input wire logic clock,
    input wire logic resetn,
    timer_link_if.counter link
);
    logic [WIDTH-1:0] count_q;
    logic zero_q;
    logic underflow_q;
    logic restart_done_q;
    logic hits_zero;

    // next tick brings the count to zero
    assign hits_zero = ~link.restart_req & (count_q == WIDTH'(1));

    // count down, reload on zero or restart; a zero preset just reloads zero
    always_ff @(posedge clock) begin
        if (!resetn) begin
            count_q <= WIDTH'(PRESET_RESET);
        end else if (link.tick) begin
            if (link.restart_req) begin
                count_q <= link.preset; // RQ10
            end else if (count_q == '0) begin
                count_q <= link.preset; // RQ6 RQ8
            end else begin
                count_q <= count_q - 1'b1; // RQ7
            end
        end
    end

    // underflow held one tick, event and restart pulses one clock
    always_ff @(posedge clock) begin
        if (!resetn) begin
            zero_q <= 1'b0;
            underflow_q <= 1'b0;
            restart_done_q <= 1'b0;
        end else begin
            zero_q <= link.tick & hits_zero; // RQ12
            restart_done_q <= link.tick & link.restart_req; // RQ11
            if (link.tick) begin
                underflow_q <= hits_zero; // RQ12
            end
        end
    end

    assign link.count = count_q;
    assign link.zero_event = zero_q;
    assign link.underflow = underflow_q;
    assign link.restart_done = restart_done_q;

    property p_restart_load;
        @(posedge clock) disable iff (!resetn)
        link.tick && link.restart_req |=> count_q == $past(link.preset);
    endproperty
    a_restart_load: assert property (p_restart_load) else $error("restart did not load"); // RQ10

    property p_zero_reload;
        @(posedge clock) disable iff (!resetn)
        link.tick && !link.restart_req && (count_q == '0) |=> count_q == $past(link.preset);
    endproperty
    a_zero_reload: assert property (p_zero_reload) else $error("no reload at zero"); // RQ6

    property p_step_down;
        @(posedge clock) disable iff (!resetn)
        link.tick && !link.restart_req && (count_q != '0) |=> count_q == $past(count_q) - 1'b1;
    endproperty
    a_step_down: assert property (p_step_down) else $error("count did not step down"); // RQ7

    property p_pulse_at_zero;
        @(posedge clock) disable iff (!resetn)
        underflow_q |-> count_q == '0;
    endproperty
    a_pulse_at_zero: assert property (p_pulse_at_zero) else $error("pulse off zero"); // RQ12
endmodule
`default_nettype wire

/* File: verif/slow_clock_periodic_timer_tb.sv */
// self-checking bench for the slow clock periodic timer
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end
module slow_clock_periodic_timer_tb
    import slow_timer_pkg::*;
();
    logic clock = 1'h0;
    logic resetn = 1'h0;
    logic slow_clock = 1'h0;
    logic slow_run = 1'h0;
    logic [1:0] slow_phase = 2'h0;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [ADDR_W-1:0] wb_adr = 8'h00;
    logic [SEL_W-1:0] wb_sel = 4'h0;
    logic [DATA_W-1:0] wb_dat_w = 32'h0000_0000;
    logic [DATA_W-1:0] wb_dat_r;
    logic wb_ack;
    logic timer_tick_clock;
    logic underflow_pulse;
    logic timer_irq;
    logic [31:0] r;
    int errors = 0;
    int total_checks = 0;
    int n;
    int p;

    slow_clock_periodic_timer slow_clock_periodic_timer_inst (
        .clock(clock),
        .resetn(resetn),
        .slow_clock(slow_clock),
        .wb_cyc(wb_cyc),
        .wb_stb(wb_stb),
        .wb_we(wb_we),
        .wb_adr(wb_adr),
        .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack),
        .timer_tick_clock(timer_tick_clock),
        .underflow_pulse(underflow_pulse),
        .timer_irq(timer_irq)
    );

    // 100 ns system clock
    always #50 clock = ~clock;

    // slow clock, one rising edge every four system clocks
    always @(posedge clock) begin
        if (slow_run) begin
            slow_phase <= slow_phase + 2'h1;
            slow_clock <= slow_phase[1];
        end
    end

    // clocks between two tick pulses for a divider code
    function automatic int tick_gap(input int code);
        return 4 << code;
    endfunction

    // clocks between two underflows at divider code 000
    function automatic int period_gap(input int preset);
        return (preset + 1) * 4;
    endfunction

    // one classic wishbone cycle, waits for ack under a bound
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d,
                       input logic [3:0] sel, output logic [31:0] rdata);
        int k;
        k = 0;
        @(posedge clock);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= d;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack !== 1'h1 && k < 50);
        if (k >= 50) errors++;
        rdata = wb_dat_r;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] x;
        bus(1'h1, a, d, s, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] rdata);
        bus(1'h0, a, 32'h0000_0000, 4'hF, rdata);
    endtask

    // waits for a rising edge of tick or underflow, counting clocks
    task automatic wait_rise(input bit uf, output int cnt);
        logic prev;
        logic cur;
        cnt = 0;
        cur = 1'h1;
        do begin
            prev = cur;
            @(posedge clock);
            cur = uf ? underflow_pulse : timer_tick_clock;
            cnt++;
        end while (!(prev === 1'h0 && cur === 1'h1) && cnt < 5000);
        if (cnt >= 5000) errors++;
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #(30000 * 100);
        errors++;
        stop_test();
    end

    // main sequence
    initial begin
        void'($urandom(32'h86ae));
        repeat (2) @(posedge clock);
        resetn <= 1'h1;
        // reset values with the slow clock held still
        rd(OFS_PRESCALER, r); `CHECK(r, 32'h0000_0000)
        rd(OFS_PRESET, r); `CHECK(r, 32'h0000_FFFF)
        rd(OFS_CTRL, r); `CHECK(r, 32'h0000_0000)
        rd(8'hFC, r); `CHECK(r, 32'h0000_0000)
        rd(OFS_COUNT, r); `CHECK(r, 32'h0000_FFFF)
        rd(OFS_IRQ_STATUS, r); `CHECK(r, 32'h0000_0000)
        `CHECK(timer_irq, 1'h0)
        slow_run <= 1'h1;
        // divider codes 000 to 101, reserved bits written at random
        for (int code = 0; code < 6; code++) begin
            wr(OFS_PRESCALER, ($urandom() & 32'hFFFF_FFF8) | 32'(code), 4'h1);
            rd(OFS_PRESCALER, r); `CHECK(r, 32'(code))
            wait_rise(1'b0, n);
            wait_rise(1'b0, n);
            wait_rise(1'b0, n); `CHECK(n, tick_gap(code))
        end
        wr(OFS_PRESCALER, 32'h0000_0000, 4'h1);
        // random short preset, restart with interrupt enabled
        p = 2 + $urandom_range(5);
        wr(OFS_PRESET, 32'(p), 4'h3);
        wr(OFS_CTRL, 32'h0000_0005, 4'h1);
        wait_rise(1'b1, n);
        wait_rise(1'b1, n); `CHECK(n, period_gap(p))
        rd(OFS_CTRL, r); `CHECK(r & 32'hFFFF_FFFD, 32'h0000_0004)
        // terminal count set at zero, cleared by the read
        wait_rise(1'b1, n);
        repeat (2) @(posedge clock);
        rd(OFS_CTRL, r); `CHECK(r[1], 1'h1)
        rd(OFS_CTRL, r); `CHECK(r[1], 1'h0)
        // byte lanes of the preset
        wr(OFS_PRESET, 32'h0000_FFFF, 4'h3);
        wr(OFS_PRESET, 32'h0000_1234, 4'h1);
        rd(OFS_PRESET, r); `CHECK(r, 32'h0000_FF34)
        // long period, then interrupt status, mask and clear
        wr(OFS_CTRL, 32'h0000_0005, 4'h1);
        repeat (20) @(posedge clock);
        rd(OFS_IRQ_STATUS, r); `CHECK(r, 32'h0000_0003)
        `CHECK(timer_irq, 1'h0)
        wr(OFS_IRQ_MASK, 32'h0000_0003, 4'h1);
        @(posedge clock);
        `CHECK(timer_irq, 1'h1)
        wr(OFS_IRQ_STATUS, 32'h0000_0003, 4'h1);
        rd(OFS_IRQ_STATUS, r); `CHECK(r, 32'h0000_0000)
        `CHECK(timer_irq, 1'h0)
        // writes leave terminal count and reserved bits alone
        rd(OFS_CTRL, r);
        wr(OFS_CTRL, 32'hFFFF_FFFA, 4'h1);
        rd(OFS_CTRL, r); `CHECK(r, 32'h0000_0018)
        // underflows with interrupt enable off leave the status bit clear
        wr(OFS_PRESET, 32'h0000_0003, 4'h3);
        wr(OFS_CTRL, 32'h0000_0019, 4'h1);
        wait_rise(1'b1, n);
        wait_rise(1'b1, n); `CHECK(n, period_gap(3))
        // underflow pulse lasts one tick period at code 000
        n = 1;
        do begin
            @(posedge clock);
            if (underflow_pulse === 1'h1) n++;
        end while (underflow_pulse === 1'h1 && n < 100);
        `CHECK(n, tick_gap(0))
        rd(OFS_IRQ_STATUS, r); `CHECK(r, 32'h0000_0002)
        stop_test();
    end
endmodule
`default_nettype wire
